// [rtl/tocr_regs.sv]
// Purpose: Temperature offset registers and second configuration register
//          behind an APB slave, with offset correction of three channels.
// Assumes: Measurements are quarter-degree two's complement, synchronous.
// Notes:   Registered decode costs one extra access cycle; outputs registered.
// Notes on behaviour
// - The first remote offset register is 8-bit read/write, resets to zero and corrects every first remote reading.
// - The local offset register is 8-bit read/write, resets to zero and corrects every local reading.
// - The second remote offset register is 8-bit read/write, resets to zero and corrects every second remote reading.
// - A range bit selects the step size of all three offsets, half a degree when clear and one degree when set.
// - Once the lock bit is set, writes to the offset registers leave them unchanged.
// - The second configuration register resets to all zeros.
// - With detection enabled, bits 3 to 1 of that register show which fan inputs carry a four-wire fan.
// - Those three fan bits are read-only and read one for a four-wire fan on inputs one, two and three.
// - Bit 4 set turns off averaging of temperature and voltage samples.
// - Bit 5 set bypasses the attenuators of the 2.5 V, core, 5 V and 12 V inputs.
// - Per-channel attenuator bypass bits act independently alongside the global bit.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps

module tocr_regs (
    input  wire logic                                   pclk,
    input  wire logic                                   presetn,
    input  wire logic                                   psel,
    input  wire logic                                   penable,
    input  wire logic                                   pwrite,
    input  wire logic [tocr_pkg::ADDR_W-1:0]            paddr,
    input  wire logic [31:0]                            pwdata,
    input  wire logic [3:0]                             pstrb,
    output logic                                        pready,
    output logic [31:0]                                 prdata,
    output logic                                        pslverr,
    input  wire tocr_pkg::tocr_meas_t                   meas_in,
    input  wire logic [2:0]                             four_wire_sense,
    output tocr_pkg::tocr_corr_t                        corr_out,
    output logic                                        averaging_bypass,
    output logic [tocr_pkg::NUM_ATTENUATOR_BYPASS-1:0]               attenuator_bypass,
    output logic [2:0]                                  fan_flags
);

    tocr_pkg::tocr_state_t s_q;
    tocr_pkg::tocr_state_t s_d;

    // Saturating signed add of a scaled offset
    function automatic logic [tocr_pkg::TEMP_W-1:0] add_offset(
        input logic [tocr_pkg::TEMP_W-1:0]   raw,
        input logic [tocr_pkg::OFFSET_W-1:0] off,
        input logic                          whole_deg
    );
        logic signed [tocr_pkg::SUM_W-1:0] raw_x;
        logic signed [tocr_pkg::SUM_W-1:0] off_x;
        logic signed [tocr_pkg::SUM_W-1:0] sum;
        logic signed [tocr_pkg::SUM_W-1:0] max_v;
        logic signed [tocr_pkg::SUM_W-1:0] min_v;
        raw_x = {{(tocr_pkg::SUM_W-tocr_pkg::TEMP_W){raw[tocr_pkg::TEMP_W-1]}}, raw};
        off_x = {{(tocr_pkg::SUM_W-tocr_pkg::OFFSET_W){off[tocr_pkg::OFFSET_W-1]}}, off};
        // Quarter-degree units: one degree is four, half a degree is two
        off_x = whole_deg ? (off_x <<< 2) : (off_x <<< 1);
        sum   = raw_x + off_x;
        max_v = 12'sh1FF;
        min_v = -12'sh200;
        // Clamp rather than wrap, a wrapped hot reading would look cold
        if (sum > max_v) begin
            add_offset = max_v[tocr_pkg::TEMP_W-1:0];
        end else if (sum < min_v) begin
            add_offset = min_v[tocr_pkg::TEMP_W-1:0];
        end else begin
            add_offset = sum[tocr_pkg::TEMP_W-1:0];
        end
    endfunction

    logic [9:0]  idx;
    logic        addr_ok;
    logic        mapped;
    logic [31:0] rd_val;
    logic        access;
    logic        do_write;

    assign idx      = paddr[tocr_pkg::ADDR_W-1:2];
    assign addr_ok  = (paddr[1:0] == 2'h0);
    assign access   = psel & penable;
    assign do_write = access & s_q.pready & pwrite & pstrb[0] & mapped;

    always_comb begin
        mapped = addr_ok;
        rd_val = tocr_pkg::READ_ZERO;
        unique case (idx)
            tocr_pkg::IDX_REMOTE1_OFFSET: rd_val[7:0] = s_q.offsets[tocr_pkg::CH_REMOTE1];
            tocr_pkg::IDX_LOCAL_OFFSET:   rd_val[7:0] = s_q.offsets[tocr_pkg::CH_LOCAL];
            tocr_pkg::IDX_REMOTE2_OFFSET: rd_val[7:0] = s_q.offsets[tocr_pkg::CH_REMOTE2];
            tocr_pkg::IDX_SECOND_CONFIG: begin
                rd_val[tocr_pkg::CFG2_DETECT_EN_BIT]                          = s_q.detect_en;
                rd_val[tocr_pkg::CFG2_FAN_FLAG_LSB +: 3]                      = s_q.fan_flags;
                rd_val[tocr_pkg::CFG2_AVG_BYPASS_BIT]                         = s_q.avg_bypass;
                rd_val[tocr_pkg::CFG2_ATTENUATOR_BYPASS_BYPASS_BIT]                        = s_q.attenuator_bypass_bypass;
            end
            tocr_pkg::IDX_LOCK_CTRL:      rd_val[tocr_pkg::LOCK_BIT] = s_q.lock;
            tocr_pkg::IDX_OFFSET_CTRL: begin
                rd_val[tocr_pkg::OFFSET_RANGE_BIT]                 = s_q.offset_range;
                rd_val[tocr_pkg::CHAN_ATTENUATOR_BYPASS_LSB +: tocr_pkg::NUM_ATTENUATOR_BYPASS] = s_q.chan_attenuator_bypass;
            end
            tocr_pkg::IDX_CORR_REMOTE1:   rd_val[tocr_pkg::TEMP_W-1:0] = s_q.corr[tocr_pkg::CH_REMOTE1];
            tocr_pkg::IDX_CORR_LOCAL:     rd_val[tocr_pkg::TEMP_W-1:0] = s_q.corr[tocr_pkg::CH_LOCAL];
            tocr_pkg::IDX_CORR_REMOTE2:   rd_val[tocr_pkg::TEMP_W-1:0] = s_q.corr[tocr_pkg::CH_REMOTE2];
            default:                      mapped = 1'b0;
        endcase
    end

    always_comb begin
        s_d = s_q;

        // Wait state in the first access cycle, answer in the second
        s_d.pready  = access & ~s_q.pready;
        s_d.pslverr = access & ~s_q.pready & ~mapped;
        if (access & ~s_q.pready & ~pwrite & mapped) begin
            s_d.prdata = rd_val;
        end else begin
            s_d.prdata = tocr_pkg::READ_ZERO;
        end

        if (do_write) begin
            unique case (idx)
                tocr_pkg::IDX_REMOTE1_OFFSET: begin
                    if (!s_q.lock) begin
                        s_d.offsets[tocr_pkg::CH_REMOTE1] = pwdata[7:0];
                    end
                end
                tocr_pkg::IDX_LOCAL_OFFSET: begin
                    if (!s_q.lock) begin
                        s_d.offsets[tocr_pkg::CH_LOCAL] = pwdata[7:0];
                    end
                end
                tocr_pkg::IDX_REMOTE2_OFFSET: begin
                    if (!s_q.lock) begin
                        s_d.offsets[tocr_pkg::CH_REMOTE2] = pwdata[7:0];
                    end
                end
                tocr_pkg::IDX_SECOND_CONFIG: begin
                    s_d.detect_en   = pwdata[tocr_pkg::CFG2_DETECT_EN_BIT];
                    s_d.avg_bypass  = pwdata[tocr_pkg::CFG2_AVG_BYPASS_BIT];
                    s_d.attenuator_bypass_bypass = pwdata[tocr_pkg::CFG2_ATTENUATOR_BYPASS_BYPASS_BIT];
                end
                // Lock holds until reset so software cannot undo it
                tocr_pkg::IDX_LOCK_CTRL: begin
                    s_d.lock = s_q.lock | pwdata[tocr_pkg::LOCK_BIT];
                end
                tocr_pkg::IDX_OFFSET_CTRL: begin
                    s_d.offset_range = pwdata[tocr_pkg::OFFSET_RANGE_BIT];
                    s_d.chan_attenuator_bypass    = pwdata[tocr_pkg::CHAN_ATTENUATOR_BYPASS_LSB +: tocr_pkg::NUM_ATTENUATOR_BYPASS];
                end
                default: begin
                end
            endcase
        end

        s_d.fan_flags = s_q.detect_en ? four_wire_sense : 3'h0;

        s_d.avg_out = s_q.avg_bypass;
        s_d.attenuator_bypass_out = {tocr_pkg::NUM_ATTENUATOR_BYPASS{s_q.attenuator_bypass_bypass}} | s_q.chan_attenuator_bypass;

        for (int ch = 0; ch < tocr_pkg::NUM_CH; ch++) begin
            s_d.corr_vld[ch] = meas_in.valid[ch];
            if (meas_in.valid[ch]) begin
                s_d.corr[ch] = add_offset(meas_in.raw[ch], s_q.offsets[ch], s_q.offset_range);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= tocr_pkg::STATE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign pready            = s_q.pready;
    assign prdata            = s_q.prdata;
    assign pslverr           = s_q.pslverr;
    assign corr_out.valid    = s_q.corr_vld;
    assign corr_out.value    = s_q.corr;
    assign averaging_bypass  = s_q.avg_out;
    assign attenuator_bypass = s_q.attenuator_bypass_out;
    assign fan_flags         = s_q.fan_flags;

endmodule

// [rtl/tocr_pkg.sv]
// Purpose: Shared constants and types for the temperature offset and
//          second configuration register block.
// Assumes: APB slave with 32-bit data, one register per aligned word.
// Notes:   Byte address of a register is four times its index.
package tocr_pkg;

    // Register indices; byte address = index * 4
    localparam logic [9:0] IDX_REMOTE1_OFFSET = 10'h070;
    localparam logic [9:0] IDX_LOCAL_OFFSET   = 10'h071;
    localparam logic [9:0] IDX_REMOTE2_OFFSET = 10'h072;
    localparam logic [9:0] IDX_SECOND_CONFIG  = 10'h073;
    localparam logic [9:0] IDX_LOCK_CTRL      = 10'h090;
    localparam logic [9:0] IDX_OFFSET_CTRL    = 10'h091;
    localparam logic [9:0] IDX_CORR_REMOTE1   = 10'h092;
    localparam logic [9:0] IDX_CORR_LOCAL     = 10'h093;
    localparam logic [9:0] IDX_CORR_REMOTE2   = 10'h094;

    localparam int ADDR_W    = 12;
    localparam int NUM_CH    = 3;
    localparam int TEMP_W    = 10;
    localparam int OFFSET_W  = 8;
    localparam int SUM_W     = 12;
    localparam int NUM_ATTENUATOR_BYPASS  = 4;

    // Second configuration register fields
    localparam int CFG2_DETECT_EN_BIT  = 0;
    localparam int CFG2_FAN_FLAG_LSB   = 1;
    localparam int CFG2_AVG_BYPASS_BIT = 4;
    localparam int CFG2_ATTENUATOR_BYPASS_BYPASS_BIT = 5;
    localparam logic [7:0] CFG2_RESET  = 8'h00;

    // Own control fields
    localparam int LOCK_BIT            = 0;
    localparam int OFFSET_RANGE_BIT    = 1;
    localparam int CHAN_ATTENUATOR_BYPASS_LSB       = 4;

    localparam logic [OFFSET_W-1:0] OFFSET_RESET = 8'h00;
    localparam logic [31:0]         READ_ZERO    = 32'h0000_0000;

    // Channel order inside arrays
    localparam int CH_REMOTE1 = 0;
    localparam int CH_LOCAL   = 1;
    localparam int CH_REMOTE2 = 2;

    typedef struct packed {
        logic [NUM_CH-1:0]             valid;
        logic [NUM_CH-1:0][TEMP_W-1:0] raw;
    } tocr_meas_t;

    typedef struct packed {
        logic [NUM_CH-1:0]             valid;
        logic [NUM_CH-1:0][TEMP_W-1:0] value;
    } tocr_corr_t;

    typedef struct packed {
        logic [NUM_CH-1:0][OFFSET_W-1:0] offsets;
        logic                            detect_en;
        logic                            avg_bypass;
        logic                            attenuator_bypass_bypass;
        logic [2:0]                      fan_flags;
        logic                            lock;
        logic                            offset_range;
        logic [NUM_ATTENUATOR_BYPASS-1:0]             chan_attenuator_bypass;
        logic [NUM_CH-1:0][TEMP_W-1:0]   corr;
        logic [NUM_CH-1:0]               corr_vld;
        logic [NUM_ATTENUATOR_BYPASS-1:0]             attenuator_bypass_out;
        logic                            avg_out;
        logic                            pready;
        logic                            pslverr;
        logic [31:0]                     prdata;
    } tocr_state_t;

    localparam tocr_state_t STATE_RESET = '0;

endpackage

// [sim/tocr_regs_chk.sv]
// Purpose: Timing checks on the offset and configuration register block.
// Assumes: The master holds each request until pready is sampled high.
// Notes:   Outputs lag the registers by one cycle.
`timescale 1ns/1ps
module tocr_regs_chk (
    input wire logic                              pclk,
    input wire logic                              presetn,
    input wire logic                              psel,
    input wire logic                              penable,
    input wire logic                              pwrite,
    input wire logic [tocr_pkg::ADDR_W-1:0]       paddr,
    input wire logic                              pready,
    input wire logic [31:0]                       prdata,
    input wire logic                              pslverr,
    input wire tocr_pkg::tocr_meas_t              meas_in,
    input wire logic [2:0]                        four_wire_sense,
    input wire tocr_pkg::tocr_corr_t              corr_out,
    input wire logic                              averaging_bypass,
    input wire logic [tocr_pkg::NUM_ATTENUATOR_BYPASS-1:0]     attenuator_bypass,
    input wire logic [2:0]                        fan_flags
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic wr_hit;
    assign wr_hit = psel && penable && pready && pwrite;
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence answer_s;
        !pready ##1 pready;
    endsequence
    ready_wait_a: assert property (setup_s |=> answer_s) else $error("pready not in second access cycle");
    err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
    read_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata outside answer");
    read_upper_a: assert property (pready |-> prdata[31:10] == 22'h0) else $error("prdata upper bits set");
    map_ok_a: assert property (pready && psel && paddr inside {12'h1C0, 12'h1C4, 12'h1C8, 12'h1CC}
        |-> !pslverr) else $error("error on mapped register");
    corr_pulse_a: assert property (1'b1 |=> corr_out.valid == $past(meas_in.valid))
        else $error("corr valid lag");
    fan_src_a: assert property ((fan_flags & ~$past(four_wire_sense)) == 3'h0)
        else $error("fan flag no source");
    avg_cause_a: assert property ($changed(averaging_bypass) |-> $past(wr_hit, 2) && $past(paddr, 2) == 12'h1CC)
        else $error("averaging bypass changed alone");
    attenuator_bypass_cause_a: assert property ($changed(attenuator_bypass) |-> $past(wr_hit, 2))
        else $error("attenuator_bypass changed alone");
endmodule
bind tocr_regs tocr_regs_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr), .meas_in(meas_in),
    .four_wire_sense(four_wire_sense), .corr_out(corr_out), .averaging_bypass(averaging_bypass),
    .attenuator_bypass(attenuator_bypass), .fan_flags(fan_flags));

// [sim/tb_top.sv]
// Purpose: Self-checking bench for the offset and configuration registers.
// Assumes: Master waits for pready, outputs one cycle behind registers.
// Notes:   Plain rows first, then measurement, lock and reset cases.
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] x; logic e;} tocr_row_t;
    logic                   pclk;
    logic                   presetn;
    logic                   psel;
    logic                   penable;
    logic                   pwrite;
    logic [11:0]            paddr;
    logic [31:0]            pwdata;
    logic [3:0]             pstrb;
    logic                   pready;
    logic [31:0]            prdata;
    logic                   pslverr;
    tocr_pkg::tocr_meas_t   meas_in;
    logic [2:0]             four_wire_sense;
    tocr_pkg::tocr_corr_t   corr_out;
    logic                   averaging_bypass;
    logic [3:0]             attenuator_bypass;
    logic [2:0]             fan_flags;
    int                     err_count = 0;
    int                     checks_done = 0;
    int                     cycles = 0;
    logic [31:0]            rd;
    logic                   er;
    tocr_row_t              rows [14];
    tocr_regs u_tocr_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .meas_in(meas_in), .four_wire_sense(four_wire_sense), .corr_out(corr_out),
        .averaging_bypass(averaging_bypass), .attenuator_bypass(attenuator_bypass), .fan_flags(fan_flags));
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    task automatic conclude();
        if (err_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // A hang ends the run as a mismatch
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            err_count++;
            conclude();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Answer taken at the very edge that samples pready high, then released
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic outs(input logic [7:0] exp);
        repeat (2) @(negedge pclk);
        chk({24'h0, averaging_bypass, attenuator_bypass, fan_flags}, {24'h0, exp});
    endtask
    task automatic meas(input logic [29:0] raw, input logic [29:0] exp);
        @(posedge pclk);
        meas_in <= {3'h7, raw};
        @(posedge pclk);
        meas_in <= '0;
        @(negedge pclk);
        chk({29'h0, corr_out.valid}, 32'h7);
        chk({2'h0, corr_out.value}, {2'h0, exp});
    endtask
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        pstrb = 4'hF;
        meas_in = '0;
        four_wire_sense = 3'h5;
        rows = '{'{1'b0, 12'h1C0, 32'h0, 32'h0, 1'b0}, '{1'b0, 12'h1C4, 32'h0, 32'h0, 1'b0},
            '{1'b0, 12'h1C8, 32'h0, 32'h0, 1'b0}, '{1'b0, 12'h1CC, 32'h0, 32'h0, 1'b0},
            '{1'b1, 12'h1C0, 32'h5A, 32'h0, 1'b0}, '{1'b0, 12'h1C0, 32'h0, 32'h5A, 1'b0},
            '{1'b1, 12'h1C4, 32'hA5, 32'h0, 1'b0}, '{1'b0, 12'h1C4, 32'h0, 32'hA5, 1'b0},
            '{1'b1, 12'h1C8, 32'h7F, 32'h0, 1'b0}, '{1'b0, 12'h1C8, 32'h0, 32'h7F, 1'b0},
            '{1'b1, 12'h1CC, 32'hFF, 32'h0, 1'b0}, '{1'b0, 12'h1CC, 32'h0, 32'h3B, 1'b0},
            '{1'b0, 12'h1C1, 32'h0, 32'h0, 1'b1}, '{1'b0, 12'h100, 32'h0, 32'h0, 1'b1}};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            chk(rd, rows[i].x);
            chk({31'h0, er}, {31'h0, rows[i].e});
        end
        outs(8'hFD);
        meas({10'h190, 10'h000, 10'h064}, {10'h1FF, 10'h34A, 10'h118});
        apb(1'b1, 12'h1CC, 32'h0);
        outs(8'h00);
        apb(1'b1, 12'h244, 32'h52);
        outs(8'h28);
        meas({10'h000, 10'h338, 10'h064}, {10'h1FC, 10'h200, 10'h1CC});
        apb(1'b0, 12'h248, 32'h0);
        chk(rd, 32'h1CC);
        apb(1'b0, 12'h24C, 32'h0);
        chk(rd, 32'h200);
        apb(1'b0, 12'h250, 32'h0);
        chk(rd, 32'h1FC);
        apb(1'b1, 12'h240, 32'h1);
        apb(1'b0, 12'h240, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, 12'h1C0, 32'h11);
        chk({31'h0, er}, 32'h0);
        apb(1'b0, 12'h1C0, 32'h0);
        chk(rd, 32'h5A);
        // Reset in mid-run must clear offsets again
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // Lock is gone after reset, so only the missing strobe may block this write
        pstrb <= 4'hE;
        apb(1'b1, 12'h1C0, 32'h33);
        pstrb <= 4'hF;
        apb(1'b0, 12'h1C0, 32'h0);
        chk(rd, 32'h0);
        conclude();
    end
endmodule
